// *** rtl/plb_pkg.sv ***
package plb_pkg;
	// register offsets
	localparam logic [7:0] PLB_CELL_ONE_CONFIG_OFS = 8'h44;
	localparam logic [7:0] PLB_CELL_TWO_CONFIG_OFS = 8'h45;
	localparam logic [7:0] PLB_FLOP_CONTROL_OFS = 8'h46;
	localparam logic [7:0] PLB_EVENT_ENABLE_OFS = 8'h47;
	// reset values
	localparam logic [7:0] PLB_CONFIG_RESET = 8'h00;
	// config fields
	localparam int PLB_SEL_LSB = 0;
	localparam int PLB_A_INV_BIT = 3;
	localparam int PLB_B_INV_BIT = 4;
	localparam int PLB_C_INV_BIT = 5;
	localparam int PLB_OUT_INV_BIT = 6;
	localparam int PLB_CHAIN_BIT = 7;
	// flop control fields
	localparam int PLB_ONE_CLEAR_BIT = 0;
	localparam int PLB_ONE_PRESET_BIT = 1;
	localparam int PLB_TWO_CLEAR_BIT = 2;
	localparam int PLB_TWO_PRESET_BIT = 3;
	// event enable fields
	localparam int PLB_ONE_POL_BIT = 0;
	localparam int PLB_ONE_EVT_BIT = 1;
	localparam int PLB_ONE_BYP_BIT = 2;
	localparam int PLB_TWO_POL_BIT = 3;
	localparam int PLB_TWO_EVT_BIT = 4;
	localparam int PLB_TWO_BYP_BIT = 5;
	// pin mux codes
	localparam logic [1:0] PLB_ROW_THREE_INPUT_C = 2'h1;
	// debounce time and its cycle count at 50 mhz
	localparam int PLB_CLK_MHZ = 50;
	localparam int PLB_DEBOUNCE_US = 70;
	localparam int PLB_DEBOUNCE_CYCLES = PLB_DEBOUNCE_US * PLB_CLK_MHZ;
	// function select encodings
	typedef enum logic [2:0] {
		PLB_FN_OFF = 3'h0,
		PLB_FN_AND = 3'h1,
		PLB_FN_OR = 3'h2,
		PLB_FN_XOR = 3'h3,
		PLB_FN_FLOP = 3'h4,
		PLB_FN_PASS_A = 3'h5,
		PLB_FN_PASS_B = 3'h6,
		PLB_FN_PASS_C = 3'h7
	} plb_fn_t;
endpackage : plb_pkg

// *** rtl/plb_cell.sv ***
`timescale 1ns/1ps
// one logic cell: input inversion, function, flop, output stage, debounce
module plb_cell
	import plb_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [7:0] config_reg,
	input wire logic in_a,
	input wire logic in_b,
	input wire logic in_c,
	input wire logic flop_preset,
	input wire logic flop_clear,
	input wire logic debounce_bypass,
	input wire logic irq_polarity,
	input wire logic event_enable,
	output logic cell_out,
	output logic event_level,
	output logic event_pulse
);
	logic a_i; // inverted-as-configured inputs
	logic b_i;
	logic c_i;
	logic b_prev; // b history for rise detect
	logic flop_q; // cell flip-flop
	logic raw_out; // function result
	logic [12:0] dbnc_cnt; // debounce counter
	logic dbnc_q; // debounced output
	logic filt; // output after optional debounce
	logic filt_prev; // for event edges
	logic active; // output at its active level
	plb_fn_t fn; // function select
	always_comb
	begin
		a_i = in_a ^ config_reg[PLB_A_INV_BIT];
		b_i = in_b ^ config_reg[PLB_B_INV_BIT];
		c_i = in_c ^ config_reg[PLB_C_INV_BIT];
		fn = plb_fn_t'(config_reg[PLB_SEL_LSB +: 3]);
	end
	// b history for the rising-edge detect
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			b_prev <= 1'b0;
		else
			b_prev <= b_i;
	end
	// flop: a on rising b; preset/clear act at once, clear wins
	// preset and clear come straight from register flops, so no glitches
	always_ff @(posedge core_clk or negedge resetn or posedge flop_clear
		or posedge flop_preset)
	begin
		if (!resetn)
			flop_q <= 1'b0;
		else if (flop_clear)
			flop_q <= 1'b0;
		else if (flop_preset)
			flop_q <= 1'b1;
		else if (b_i && !b_prev)
			flop_q <= a_i;
	end
	// function mux
	always_comb
	begin
		case (fn)
			PLB_FN_OFF: raw_out = 1'b0;
			PLB_FN_AND: raw_out = a_i & b_i & c_i;
			PLB_FN_OR: raw_out = a_i | b_i | c_i;
			PLB_FN_XOR: raw_out = a_i ^ b_i ^ c_i;
			PLB_FN_FLOP: raw_out = flop_q;
			PLB_FN_PASS_A: raw_out = a_i;
			PLB_FN_PASS_B: raw_out = b_i;
			PLB_FN_PASS_C: raw_out = c_i;
			default: raw_out = 1'b0;
		endcase
	end
	// output invert; disabled cell stays low
	always_comb
	begin
		if (fn == PLB_FN_OFF)
			cell_out = 1'b0;
		else
			cell_out = raw_out ^ config_reg[PLB_OUT_INV_BIT];
	end
	// debounce: accept a new level only after it holds steady
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dbnc_q <= 1'b0;
			dbnc_cnt <= '0;
		end
		else if (cell_out == dbnc_q)
			dbnc_cnt <= '0;
		else if (dbnc_cnt == 13'(PLB_DEBOUNCE_CYCLES - 1))
		begin
			dbnc_q <= cell_out;
			dbnc_cnt <= '0;
		end
		else
			dbnc_cnt <= dbnc_cnt + 13'h1;
	end
	always_comb
	begin
		filt = debounce_bypass ? cell_out : dbnc_q;
		active = ~(filt ^ irq_polarity);
	end
	// event edge detect
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			filt_prev <= 1'b0;
		else
			filt_prev <= filt;
	end
	// level and change pulse, gated by enable and disable state
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			event_level <= 1'b0;
			event_pulse <= 1'b0;
		end
		else
		begin
			event_level <= event_enable && fn != PLB_FN_OFF
				&& active;
			event_pulse <= event_enable && fn != PLB_FN_OFF
				&& (filt != filt_prev);
		end
	end
endmodule : plb_cell

// *** rtl/plb_top.sv ***
`timescale 1ns/1ps
// two programmable logic cells with their register file
module plb_top
	import plb_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic reg_wr, // one-cycle register write strobe
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata, // registered read data
	input wire logic row_zero_pin, // cell two a when not chained
	input wire logic cell_one_input_a,
	input wire logic cell_one_input_b,
	input wire logic row_three_pin, // cell one input c source
	input wire logic [1:0] row_three_mode, // pin mux field, held elsewhere
	input wire logic cell_two_input_b,
	input wire logic cell_two_input_c,
	input wire logic column_nine_mode, // pin mux bit, held elsewhere
	output logic cell_one_output,
	output logic cell_two_output,
	output logic column_nine_out,
	output logic column_nine_oe,
	output logic row_zero_free, // pin free for gpio or keypad
	output logic cell_one_event_level,
	output logic cell_one_event_pulse,
	output logic cell_two_event_level,
	output logic cell_two_event_pulse
);
	logic [7:0] logic_cell_one_config;
	logic [7:0] logic_cell_two_config;
	logic [7:0] logic_flipflop_control;
	logic [7:0] logic_event_interrupt_enable;
	logic cell_one_input_c; // muxed from the row three pin
	logic cell_two_input_a; // muxed from pin or cell one
	logic cell_chain_enable;
	// register writes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			logic_cell_one_config <= PLB_CONFIG_RESET;
			logic_cell_two_config <= PLB_CONFIG_RESET;
			logic_flipflop_control <= PLB_CONFIG_RESET;
			logic_event_interrupt_enable <= PLB_CONFIG_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				PLB_CELL_ONE_CONFIG_OFS: logic_cell_one_config <= reg_wdata;
				PLB_CELL_TWO_CONFIG_OFS: logic_cell_two_config <= reg_wdata;
				PLB_FLOP_CONTROL_OFS: logic_flipflop_control <= reg_wdata;
				PLB_EVENT_ENABLE_OFS:
					logic_event_interrupt_enable <= reg_wdata;
				default: ; // other addresses belong elsewhere
			endcase
		end
	end
	// registered read data; unmapped addresses read zero
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else
		begin
			case (reg_addr)
				PLB_CELL_ONE_CONFIG_OFS: reg_rdata <= logic_cell_one_config;
				PLB_CELL_TWO_CONFIG_OFS: reg_rdata <= logic_cell_two_config;
				PLB_FLOP_CONTROL_OFS: reg_rdata <= logic_flipflop_control;
				PLB_EVENT_ENABLE_OFS:
					reg_rdata <= logic_event_interrupt_enable;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
	// input muxing
	always_comb
	begin
		cell_chain_enable = logic_cell_two_config[PLB_CHAIN_BIT];
		cell_one_input_c = (row_three_mode == PLB_ROW_THREE_INPUT_C)
			? row_three_pin : 1'b0;
		cell_two_input_a = cell_chain_enable
			? cell_one_output : row_zero_pin;
		row_zero_free = cell_chain_enable;
	end
	// cell one
	plb_cell u_cell_one (
		.core_clk(core_clk),
		.resetn(resetn),
		.config_reg(logic_cell_one_config),
		.in_a(cell_one_input_a),
		.in_b(cell_one_input_b),
		.in_c(cell_one_input_c),
		.flop_preset(logic_flipflop_control[PLB_ONE_PRESET_BIT]),
		.flop_clear(logic_flipflop_control[PLB_ONE_CLEAR_BIT]),
		.debounce_bypass(logic_event_interrupt_enable[PLB_ONE_BYP_BIT]),
		.irq_polarity(logic_event_interrupt_enable[PLB_ONE_POL_BIT]),
		.event_enable(logic_event_interrupt_enable[PLB_ONE_EVT_BIT]),
		.cell_out(cell_one_output),
		.event_level(cell_one_event_level),
		.event_pulse(cell_one_event_pulse)
	);
	// cell two
	plb_cell u_cell_two (
		.core_clk(core_clk),
		.resetn(resetn),
		.config_reg(logic_cell_two_config),
		.in_a(cell_two_input_a),
		.in_b(cell_two_input_b),
		.in_c(cell_two_input_c),
		.flop_preset(logic_flipflop_control[PLB_TWO_PRESET_BIT]),
		.flop_clear(logic_flipflop_control[PLB_TWO_CLEAR_BIT]),
		.debounce_bypass(logic_event_interrupt_enable[PLB_TWO_BYP_BIT]),
		.irq_polarity(logic_event_interrupt_enable[PLB_TWO_POL_BIT]),
		.event_enable(logic_event_interrupt_enable[PLB_TWO_EVT_BIT]),
		.cell_out(cell_two_output),
		.event_level(cell_two_event_level),
		.event_pulse(cell_two_event_pulse)
	);
	// column nine pin drive
	always_comb
	begin
		column_nine_out = cell_two_output;
		column_nine_oe = column_nine_mode;
	end
endmodule : plb_top

// *** dv/plb_assertions.sv ***
`timescale 1ns/1ps
// column nine pin checks, and port checks of both cells against register writes
module plb_assertions
	import plb_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic cell_one_input_a,
	input wire logic cell_two_input_b,
	input wire logic column_nine_mode,
	input wire logic cell_one_output,
	input wire logic cell_two_output,
	input wire logic column_nine_out,
	input wire logic column_nine_oe,
	input wire logic row_zero_free,
	input wire logic cell_one_event_level,
	input wire logic cell_one_event_pulse,
	input wire logic cell_two_event_level,
	input wire logic cell_two_event_pulse
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// write strobes for the two config registers and the event enable register
	wire w1 = reg_wr && reg_addr == PLB_CELL_ONE_CONFIG_OFS;
	wire w2 = reg_wr && reg_addr == PLB_CELL_TWO_CONFIG_OFS;
	wire we = reg_wr && reg_addr == PLB_EVENT_ENABLE_OFS;
	pin_oe_a: assert property (
		column_nine_oe == column_nine_mode) else $error("col nine oe");
	pin_level_a: assert property (
		column_nine_oe |-> column_nine_out == cell_two_output)
		else $error("col nine level");
	row_free_a: assert property (
		w2 |=> row_zero_free == $past(reg_wdata[7])) else $error("row free");
	one_quiet_a: assert property (
		we && !reg_wdata[1] |-> ##3
		!cell_one_event_level && !cell_one_event_pulse) else $error("ev1");
	two_quiet_a: assert property (
		we && !reg_wdata[4] |-> ##3
		!cell_two_event_level && !cell_two_event_pulse) else $error("ev2");
	off_low_a: assert property (
		w1 && reg_wdata[2:0] == 3'h0 |=> !cell_one_output) else $error("off");
	pass_one_a: assert property (
		w1 && reg_wdata[2:0] == 3'h5 |=> cell_one_output ==
		(cell_one_input_a ^ $past(reg_wdata[3]) ^ $past(reg_wdata[6])))
		else $error("pass one");
	pass_two_a: assert property (
		w2 && reg_wdata[2:0] == 3'h6 |=> cell_two_output ==
		(cell_two_input_b ^ $past(reg_wdata[4]) ^ $past(reg_wdata[6])))
		else $error("pass two");
endmodule : plb_assertions
bind plb_top plb_assertions u_chk (.*);

// *** dv/plb_pin_model.sv ***
`timescale 1ns/1ps
// far-side pins: take the requested levels just after each edge
module plb_pin_model
(
	input wire logic core_clk,
	input wire logic [5:0] drive,
	output logic row_zero_pin,
	output logic cell_one_input_a,
	output logic cell_one_input_b,
	output logic row_three_pin,
	output logic cell_two_input_b,
	output logic cell_two_input_c
);
	always @(posedge core_clk or drive)
		{cell_two_input_c, cell_two_input_b, row_three_pin, cell_one_input_b,
			cell_one_input_a, row_zero_pin} <= #1 drive;
endmodule : plb_pin_model

// *** dv/tb.sv ***
`timescale 1ns/1ps
// bench for the two logic cells
module tb;
	import plb_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic reg_wr = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [1:0] row_three_mode = 2'h1;
	logic column_nine_mode = 1'b1;
	logic [5:0] drive = 6'h00;
	logic [7:0] reg_rdata;
	logic row_zero_pin, cell_one_input_a, cell_one_input_b, row_three_pin;
	logic cell_two_input_b, cell_two_input_c, cell_one_output;
	logic cell_two_output, column_nine_out, column_nine_oe, row_zero_free;
	logic cell_one_event_level, cell_one_event_pulse;
	logic cell_two_event_level, cell_two_event_pulse;
	wire logic [1:0] y = {cell_two_output, cell_one_output};
	wire logic [1:0] lv = {cell_two_event_level, cell_one_event_level};
	int num_errors = 0;
	int cmp_count = 0;
	always #10 core_clk = ~core_clk;
	plb_pin_model u_pins (.*);
	plb_top u_dut (.*);
	task automatic chk(input logic [7:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t %s %h %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	// a gap cycle keeps a following write from re-raising the strobe at once
	task automatic wr(input logic [7:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, exp);
		reg_addr = a;
		cyc(2);
		chk(reg_rdata, exp, "read");
	endtask : rd
	task automatic pin(input logic [5:0] v);
		drive = v;
		cyc(2);
	endtask : pin
	// drive pins and collect event pulses for six cycles
	task automatic watch(input logic [5:0] v, output logic [1:0] s);
		drive = v;
		s = 2'h0;
		repeat (6)
		begin
			cyc(1);
			s |= {cell_two_event_pulse, cell_one_event_pulse};
		end
	endtask : watch
	function automatic logic fn(input logic [2:0] s, v);
		case (s)
			3'h1: return &v;
			3'h2: return |v;
			3'h3: return ^v;
			3'h5: return v[0];
			3'h6: return v[1];
			3'h7: return v[2];
			default: return 1'b0;
		endcase
	endfunction : fn
	// reset values, read back, unmapped place
	task automatic t_regs();
		logic [7:0] v [4] = '{8'h7b, 8'hcd, 8'h0f, 8'h2a};
		for (int i = 0; i < 4; i++)
			rd(8'h44 + 8'(i), PLB_CONFIG_RESET);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h44 + 8'(i), v[i]);
			rd(8'h44 + 8'(i), v[i]);
		end
		wr(8'h48, 8'hff);
		rd(8'h48, 8'h00);
		rd(8'h44, 8'h7b);
	endtask : t_regs
	// every select code (flop not checked), three inversion mixes and every input pattern on both cells
	task automatic t_func();
		logic [7:0] inv [3] = '{8'h00, 8'h48, 8'h30};
		logic [7:0] c;
		logic [2:0] x;
		logic [7:0] e;
		for (int s = 0; s < 8; s++)
			for (int k = 0; k < 3; k++)
				for (int v = 0; v < 8; v++)
				begin
					c = inv[k] | 8'(s);
					x = 3'(v);
					wr(PLB_CELL_ONE_CONFIG_OFS, c);
					wr(PLB_CELL_TWO_CONFIG_OFS, c);
					pin({x[2:1], x, x[0]});
					x = x ^ c[5:3];
					e = (s == 0) ? 8'h00 : 8'(fn(3'(s), x) ^ c[6]);
					if (s != 4)
					begin
						chk(8'(y[0]), e, "fn 1");
						chk(8'(y[1]), e, "fn 2");
					end
				end
	endtask : t_func
	// chaining, row three routing, column nine drive
	task automatic t_chain();
		wr(PLB_CELL_ONE_CONFIG_OFS, 8'h05);
		wr(PLB_CELL_TWO_CONFIG_OFS, 8'h85);
		pin(6'h02);
		chk(8'(column_nine_out), 8'h01, "chain");
		chk(8'(row_zero_free), 8'h01, "row free");
		wr(PLB_CELL_TWO_CONFIG_OFS, 8'h8d);
		pin(6'h01);
		chk(8'(cell_two_output), 8'h01, "chain inv");
		wr(PLB_CELL_ONE_CONFIG_OFS, 8'h07);
		row_three_mode = 2'h0;
		column_nine_mode = 1'b0;
		pin(6'h08);
		chk({6'h0, column_nine_oe, cell_one_output}, 8'h00, "mux");
		row_three_mode = 2'h1;
		column_nine_mode = 1'b1;
	endtask : t_chain
	// flop preset/clear priority, then capture on b rise
	task automatic t_flop();
		logic [7:0] ctl [6] = '{8'h02, 8'h08, 8'h01, 8'h04, 8'h0f, 8'h00};
		logic [7:0] q [6] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h00};
		wr(PLB_CELL_ONE_CONFIG_OFS, 8'h04);
		wr(PLB_CELL_TWO_CONFIG_OFS, 8'h04);
		pin(6'h03);
		for (int i = 0; i < 6; i++)
		begin
			wr(PLB_FLOP_CONTROL_OFS, ctl[i]);
			cyc(3);
			chk(8'(y), q[i], "flop ctl");
		end
		pin(6'h17);
		cyc(2);
		chk(8'(y), 8'h03, "flop clk");
	endtask : t_flop
	// enable, polarity, bypass and debounce of events
	task automatic t_event();
		logic [1:0] s;
		wr(PLB_CELL_ONE_CONFIG_OFS, 8'h05);
		wr(PLB_CELL_TWO_CONFIG_OFS, 8'h05);
		pin(6'h00);
		wr(PLB_EVENT_ENABLE_OFS, 8'h3f);
		watch(6'h03, s);
		chk(8'(s), 8'h03, "bypass pulse");
		chk(8'(lv), 8'h03, "act high");
		wr(PLB_EVENT_ENABLE_OFS, 8'h36);
		cyc(3);
		chk(8'(lv), 8'h00, "act low");
		wr(PLB_EVENT_ENABLE_OFS, 8'h24);
		watch(6'h00, s);
		chk(8'(s), 8'h00, "disabled");
		wr(PLB_EVENT_ENABLE_OFS, 8'h1b);
		watch(6'h03, s);
		cyc(100);
		chk({4'h0, s, lv}, 8'h00, "bouncing");
		cyc(PLB_DEBOUNCE_CYCLES);
		chk(8'(lv), 8'h03, "settled");
	endtask : t_event
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	initial
	begin
		cyc(16);
		resetn = 1'b1;
		cyc(1);
		t_regs();
		t_func();
		t_chain();
		t_flop();
		t_event();
		print_verdict();
	end
	// hang guard
	initial
	begin
		#2000000;
		num_errors++;
		$display("MISMATCH %0t timeout", $time);
		print_verdict();
	end
endmodule : tb
